// >>> pkg/sqa_pkg.sv
// constants, state and opcode types for the square-accumulate and
// status-op execution block.
// assumes a single core clock; no imports, every use is sqa_pkg::name.
package sqa_pkg;

	// ==========================================================
	// widths and aux register count
	localparam int DATA_W = 16;
	localparam int ACC_W  = 32;
	localparam int AUX_N  = 8;

	// ==========================================================
	// opcodes on the instruction port
	typedef enum logic [2:0] {
		OP_NONE        = 3'h0,
		OP_SQUARE_ADD  = 3'h1,
		OP_SQUARE_SUB  = 3'h2,
		OP_STORE_ST    = 3'h3,
		OP_STORE_ST_N  = 3'h4,
		OP_STORE_ST1   = 3'h5,
		OP_SET_SXM     = 3'h6,
		OP_SET_TXM_TC  = 3'h7
	} sqa_op_type;

	// sub-select for op code 7: set test/control or set transmit mode
	localparam logic SUB_TEST_CONTROL = 1'h0;
	localparam logic SUB_TRANSMIT     = 1'h1;

	// ==========================================================
	// indirect modifier codes
	localparam logic [1:0] MOD_NONE = 2'h0;
	localparam logic [1:0] MOD_INC  = 2'h1;
	localparam logic [1:0] MOD_DEC  = 2'h2;

	// ==========================================================
	// product shift mode codes and shift amounts
	localparam logic [1:0] PM_NONE   = 2'h0;
	localparam logic [1:0] PM_LEFT1  = 2'h1;
	localparam logic [1:0] PM_LEFT4  = 2'h2;
	localparam logic [1:0] PM_RIGHT6 = 2'h3;
	localparam int SHIFT_L1 = 1;
	localparam int SHIFT_L4 = 4;
	localparam int SHIFT_R6 = 6;

	// ==========================================================
	// execution states, one-hot
	typedef enum logic [2:0] {
		ST_IDLE = 3'b001,
		ST_WAIT = 3'b010,
		ST_LOAD = 3'b100
	} sqa_state_type;

	// ==========================================================
	// register port offsets (word index)
	localparam logic [3:0] OFS_ST0    = 4'h0;
	localparam logic [3:0] OFS_ST1    = 4'h1;
	localparam logic [3:0] OFS_ACC_LO = 4'h2;
	localparam logic [3:0] OFS_ACC_HI = 4'h3;
	localparam logic [3:0] OFS_P_LO   = 4'h4;
	localparam logic [3:0] OFS_P_HI   = 4'h5;
	localparam logic [3:0] OFS_TREG   = 4'h6;
	localparam logic [3:0] OFS_CTRL   = 4'h7;
	localparam logic [3:0] OFS_AUX0   = 4'h8;

	// ==========================================================
	// status word and control word field positions
	localparam int ST0_ARP_LSB = 13;
	localparam int ST1_TC_BIT  = 11;
	localparam int ST1_SXM_BIT = 10;
	localparam int ST1_TXM_BIT = 2;
	localparam int ST1_PM_LSB  = 0;
	localparam int CTRL_GEN_BIT = 0;

	// ==========================================================
	// reset values
	localparam logic [1:0]  PM_RESET   = 2'h0;
	localparam logic        SXM_RESET  = 1'h1;
	localparam logic        TC_RESET   = 1'h0;
	localparam logic        TXM_RESET  = 1'h0;
	localparam logic [2:0]  ARP_RESET  = 3'h0;
	localparam logic        GEN_RESET  = 1'h0;
	localparam logic [15:0] WORD_RESET = 16'h0000;

endpackage

// >>> logic/sqa_product_shift.sv
// product shifter: scales the product register per the shift mode.
// assumes a 32-bit two's complement product; purely combinational.
`timescale 1ns/1ps
`default_nettype none
module sqa_product_shift (
	// product in
	input  wire logic [31:0] product,
	input  wire logic [1:0]  shift_mode,
	// scaled product out
	output logic      [31:0] shifted
);

	// ==========================================================
	// shift select
	wire logic [31:0] left_one;
	wire logic [31:0] left_four;
	wire logic [31:0] right_six;

	// left shifts zero fill, right shift keeps the sign
	assign left_one  = product << sqa_pkg::SHIFT_L1; // RULE_09
	assign left_four = product << sqa_pkg::SHIFT_L4; // RULE_09
	assign right_six = 32'($signed(product) >>> sqa_pkg::SHIFT_R6); // RULE_09

	assign shifted = (shift_mode == sqa_pkg::PM_LEFT1)  ? left_one  :
	                 (shift_mode == sqa_pkg::PM_LEFT4)  ? left_four :
	                 (shift_mode == sqa_pkg::PM_RIGHT6) ? right_six :
	                 product; // RULE_09

endmodule
`default_nettype wire

// >>> logic/sqa_exec.sv
// execution of square-accumulate, store-status and set-bit instructions.
// assumes data memory answers a read strobe with data one cycle later,
// and the instruction source holds an instruction until instr_ready.
//
// What this block does
// RULE_01: square-and-add adds the mode-shifted product to the accumulator, then squares the memory operand into the product.
// RULE_02: square-and-subtract subtracts the mode-shifted product from the accumulator, then squares the memory operand into the product.
// RULE_03: plain store-status writes status word zero to the addressed data word, direct or indirect.
// RULE_04: store-status with a selector writes the chosen status word to data memory, direct or indirect.
// RULE_05: store-status-one writes all of status word one to the addressed data word.
// RULE_06: set-sign-extension forces the sign-extend enable bit to one.
// RULE_07: set-test-control forces the test/control flag to one and touches nothing else.
// RULE_08: set-transmit-mode forces the transmit mode bit to one, only on the older generation.
// RULE_09: the shift mode gives no shift, left one, left four, or arithmetic right six, left shifts zero filled.
// RULE_10: indirect forms update the current aux register per the modifier and may load a new pointer select.
//
// Added by the designer: the placing of the registers and the address-and-strobe port.
`timescale 1ns/1ps
`default_nettype none
module sqa_exec (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        reset_n,
	// instruction port
	input  wire logic        instr_valid,
	input  wire logic [2:0]  instr_op,
	input  wire logic        instr_sub,
	input  wire logic        instr_indirect,
	input  wire logic [15:0] instr_direct_addr,
	input  wire logic [1:0]  instr_modifier,
	input  wire logic        instr_next_valid,
	input  wire logic [2:0]  instr_next_arp,
	input  wire logic        instr_status_sel,
	output logic             instr_ready,
	// data memory port
	output logic             mem_rd,
	output logic             mem_wr,
	output logic      [15:0] mem_addr,
	output logic      [15:0] mem_wdata,
	input  wire logic [15:0] mem_rdata,
	// register port
	input  wire logic [3:0]  reg_addr,
	input  wire logic [15:0] reg_wdata,
	input  wire logic        reg_wr,
	input  wire logic        reg_rd,
	output logic      [15:0] reg_rdata,
	// status bits
	output logic             sign_extend_enable,
	output logic             test_control_flag,
	output logic             serial_transmit_mode_bit
);

	// ==========================================================
	// reset release
	logic rst_meta_reg;
	logic rst_n_sync;

	always_ff @(posedge clk or negedge reset_n) begin
		if (!reset_n) begin
			rst_meta_reg <= 1'h0;
			rst_n_sync   <= 1'h0;
		end else begin
			rst_meta_reg <= 1'h1;
			rst_n_sync   <= rst_meta_reg;
		end
	end

	// ==========================================================
	// state
	sqa_pkg::sqa_state_type state_reg;
	sqa_pkg::sqa_state_type state_next;
	logic [31:0] acc_reg;
	logic [31:0] acc_next;
	logic [31:0] product_reg;
	logic [15:0] treg_reg;
	logic [1:0]  pm_reg;
	logic        sxm_reg;
	logic        tc_reg;
	logic        txm_reg;
	logic [2:0]  arp_reg;
	logic        gen_reg;
	logic [15:0] aux_reg [sqa_pkg::AUX_N];
	logic        ready_reg;
	logic        rd_reg;
	logic        wr_reg;
	logic [15:0] addr_reg;
	logic [15:0] wdata_reg;
	logic [15:0] rdata_reg;

	// ==========================================================
	// decode
	wire logic        take;
	wire logic        is_sqr_add;
	wire logic        is_sqr_sub;
	wire logic        is_sqr;
	wire logic        is_st0;
	wire logic        is_st_n;
	wire logic        is_st1;
	wire logic        is_store;
	wire logic        is_sxm;
	wire logic        is_tc;
	wire logic        is_txm;
	wire logic        uses_mem;
	wire logic        ind_step;
	wire logic [15:0] cur_aux;
	wire logic [15:0] aux_stepped;
	wire logic [15:0] op_addr;
	wire logic [15:0] st0_word;
	wire logic [15:0] st1_word;
	wire logic [15:0] store_word;
	wire logic [31:0] p_shifted;
	wire logic [31:0] square;

	assign take       = instr_valid && ready_reg;
	assign is_sqr_add = instr_op == sqa_pkg::OP_SQUARE_ADD;
	assign is_sqr_sub = instr_op == sqa_pkg::OP_SQUARE_SUB;
	assign is_sqr     = is_sqr_add || is_sqr_sub;
	assign is_st0     = instr_op == sqa_pkg::OP_STORE_ST;
	assign is_st_n    = instr_op == sqa_pkg::OP_STORE_ST_N;
	assign is_st1     = instr_op == sqa_pkg::OP_STORE_ST1;
	assign is_store   = is_st0 || is_st_n || is_st1;
	assign is_sxm     = instr_op == sqa_pkg::OP_SET_SXM;
	assign is_tc      = instr_op == sqa_pkg::OP_SET_TXM_TC &&
	                    instr_sub == sqa_pkg::SUB_TEST_CONTROL;
	// transmit mode exists only when the older generation is selected
	assign is_txm     = instr_op == sqa_pkg::OP_SET_TXM_TC &&
	                    instr_sub == sqa_pkg::SUB_TRANSMIT && gen_reg; // RULE_08
	assign uses_mem   = is_sqr || is_store;
	assign ind_step   = take && uses_mem && instr_indirect;

	// indirect address is the current aux register before modification
	assign cur_aux     = aux_reg[arp_reg];
	assign aux_stepped = (instr_modifier == sqa_pkg::MOD_INC) ?
	                     cur_aux + 16'h0001 :
	                     (instr_modifier == sqa_pkg::MOD_DEC) ?
	                     cur_aux - 16'h0001 : cur_aux; // RULE_10
	assign op_addr     = instr_indirect ? cur_aux : instr_direct_addr;

	assign st0_word = {arp_reg, 13'h0000};
	assign st1_word = {4'h0, tc_reg, sxm_reg, 7'h00, txm_reg, pm_reg};
	assign store_word = is_st1 ? st1_word : // RULE_05
	                    (is_st_n && instr_status_sel) ? st1_word : // RULE_04
	                    st0_word; // RULE_03

	sqa_product_shift u_shift (
		.product    (product_reg),
		.shift_mode (pm_reg),
		.shifted    (p_shifted)
	);

	assign square = 32'($signed(mem_rdata) * $signed(mem_rdata));

	// accumulate happens at dispatch, before the new square lands
	assign acc_next = is_sqr_add ? acc_reg + p_shifted : // RULE_01
	                  acc_reg - p_shifted; // RULE_02

	// ==========================================================
	// sequencer
	always_comb begin
		state_next = state_reg;
		case (state_reg)
			sqa_pkg::ST_IDLE: begin
				if (take && is_sqr) begin
					state_next = sqa_pkg::ST_WAIT;
				end
			end
			sqa_pkg::ST_WAIT: begin
				state_next = sqa_pkg::ST_LOAD;
			end
			sqa_pkg::ST_LOAD: begin
				state_next = sqa_pkg::ST_IDLE;
			end
			default: begin
				state_next = sqa_pkg::ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			state_reg <= sqa_pkg::ST_IDLE;
			ready_reg <= 1'h0;
		end else begin
			state_reg <= state_next;
			ready_reg <= state_next == sqa_pkg::ST_IDLE;
		end
	end

	// ==========================================================
	// register port decode
	wire logic        wr_st1;
	wire logic        wr_ctrl;
	wire logic        wr_acc_lo;
	wire logic        wr_acc_hi;
	wire logic [15:0] rd_value;

	assign wr_st1    = reg_wr && reg_addr == sqa_pkg::OFS_ST1;
	assign wr_ctrl   = reg_wr && reg_addr == sqa_pkg::OFS_CTRL;
	assign wr_acc_lo = reg_wr && reg_addr == sqa_pkg::OFS_ACC_LO;
	assign wr_acc_hi = reg_wr && reg_addr == sqa_pkg::OFS_ACC_HI;

	assign rd_value = (reg_addr == sqa_pkg::OFS_ST0)    ? st0_word :
	                  (reg_addr == sqa_pkg::OFS_ST1)    ? st1_word :
	                  (reg_addr == sqa_pkg::OFS_ACC_LO) ? acc_reg[15:0] :
	                  (reg_addr == sqa_pkg::OFS_ACC_HI) ? acc_reg[31:16] :
	                  (reg_addr == sqa_pkg::OFS_P_LO)   ? product_reg[15:0] :
	                  (reg_addr == sqa_pkg::OFS_P_HI)   ? product_reg[31:16] :
	                  (reg_addr == sqa_pkg::OFS_TREG)   ? treg_reg :
	                  (reg_addr == sqa_pkg::OFS_CTRL)   ? {15'h0000, gen_reg} :
	                  cur_aux_at(reg_addr);

	function automatic logic [15:0] cur_aux_at(input logic [3:0] a);
		cur_aux_at = aux_reg[a[2:0]];
	endfunction

	// ==========================================================
	// arithmetic registers
	// an instruction update wins over a software write in the same cycle
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			acc_reg     <= 32'h00000000;
			product_reg <= 32'h00000000;
			treg_reg    <= sqa_pkg::WORD_RESET;
		end else if (take && is_sqr) begin
			acc_reg <= acc_next; // RULE_01 RULE_02
		end else if (state_reg == sqa_pkg::ST_LOAD) begin
			treg_reg    <= mem_rdata; // RULE_01 RULE_02
			product_reg <= square; // RULE_01 RULE_02
		end else if (wr_acc_lo) begin
			acc_reg[15:0] <= reg_wdata;
		end else if (wr_acc_hi) begin
			acc_reg[31:16] <= reg_wdata;
		end
	end

	// ==========================================================
	// status bits
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			pm_reg  <= sqa_pkg::PM_RESET;
			sxm_reg <= sqa_pkg::SXM_RESET;
			tc_reg  <= sqa_pkg::TC_RESET;
			txm_reg <= sqa_pkg::TXM_RESET;
			gen_reg <= sqa_pkg::GEN_RESET;
		end else begin
			if (wr_st1) begin
				pm_reg  <= reg_wdata[sqa_pkg::ST1_PM_LSB +: 2];
				sxm_reg <= reg_wdata[sqa_pkg::ST1_SXM_BIT];
				txm_reg <= reg_wdata[sqa_pkg::ST1_TXM_BIT];
				tc_reg  <= reg_wdata[sqa_pkg::ST1_TC_BIT];
			end
			// a set instruction beats a same-cycle software write
			if (take && is_sxm) begin
				sxm_reg <= 1'h1; // RULE_06
			end
			if (take && is_tc) begin
				tc_reg <= 1'h1; // RULE_07
			end
			if (take && is_txm) begin
				txm_reg <= 1'h1; // RULE_08
			end
			if (wr_ctrl) begin
				gen_reg <= reg_wdata[sqa_pkg::CTRL_GEN_BIT];
			end
		end
	end

	// ==========================================================
	// aux pointer and aux registers
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			arp_reg <= sqa_pkg::ARP_RESET;
		end else if (ind_step && instr_next_valid) begin
			arp_reg <= instr_next_arp; // RULE_10
		end else if (reg_wr && reg_addr == sqa_pkg::OFS_ST0) begin
			arp_reg <= reg_wdata[sqa_pkg::ST0_ARP_LSB +: 3];
		end
	end

	genvar gi;
	generate
		for (gi = 0; gi < sqa_pkg::AUX_N; gi++) begin : g_aux
			wire logic hit_step;
			wire logic hit_wr;
			assign hit_step = ind_step && arp_reg == 3'(gi);
			assign hit_wr   = reg_wr && reg_addr == 4'(sqa_pkg::OFS_AUX0 + gi);
			always_ff @(posedge clk or negedge rst_n_sync) begin
				if (!rst_n_sync) begin
					aux_reg[gi] <= sqa_pkg::WORD_RESET;
				end else if (hit_step) begin
					aux_reg[gi] <= aux_stepped; // RULE_10
				end else if (hit_wr) begin
					aux_reg[gi] <= reg_wdata;
				end
			end
		end
	endgenerate

	// ==========================================================
	// data memory strobes
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			rd_reg    <= 1'h0;
			wr_reg    <= 1'h0;
			addr_reg  <= sqa_pkg::WORD_RESET;
			wdata_reg <= sqa_pkg::WORD_RESET;
		end else begin
			rd_reg <= take && is_sqr; // RULE_01 RULE_02
			wr_reg <= take && is_store; // RULE_03 RULE_04 RULE_05
			if (take && uses_mem) begin
				addr_reg <= op_addr;
			end
			if (take && is_store) begin
				wdata_reg <= store_word; // RULE_03 RULE_04 RULE_05
			end
		end
	end

	// ==========================================================
	// register read data, one cycle after the strobe
	always_ff @(posedge clk or negedge rst_n_sync) begin
		if (!rst_n_sync) begin
			rdata_reg <= sqa_pkg::WORD_RESET;
		end else if (reg_rd) begin
			rdata_reg <= rd_value;
		end
	end

	// ==========================================================
	// outputs
	assign instr_ready              = ready_reg;
	assign mem_rd                   = rd_reg;
	assign mem_wr                   = wr_reg;
	assign mem_addr                 = addr_reg;
	assign mem_wdata                = wdata_reg;
	assign reg_rdata                = rdata_reg;
	assign sign_extend_enable       = sxm_reg;
	assign test_control_flag        = tc_reg;
	assign serial_transmit_mode_bit = txm_reg;

endmodule
`default_nettype wire

// >>> verification/sqa_exec_asserts.sv
// concurrent checks on the square-accumulate and status-op block.
// assumes it is bound onto sqa_exec and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module sqa_exec_asserts (
	// clock and reset
	input wire logic        clk,
	input wire logic        reset_n,
	// instruction port
	input wire logic        instr_valid,
	input wire logic [2:0]  instr_op,
	input wire logic        instr_sub,
	input wire logic        instr_ready,
	// memory and register ports
	input wire logic        mem_rd,
	input wire logic        mem_wr,
	input wire logic [15:0] mem_wdata,
	input wire logic [3:0]  reg_addr,
	input wire logic        reg_wr,
	// status bits
	input wire logic        sign_extend_enable,
	input wire logic        test_control_flag,
	input wire logic        serial_transmit_mode_bit
);
	// ==========================================================
	// helpers
	default clocking cb @(posedge clk); endclocking
	default disable iff (!reset_n);
	wire take = instr_valid && instr_ready;
	wire take_sq = take && (instr_op == sqa_pkg::OP_SQUARE_ADD ||
		instr_op == sqa_pkg::OP_SQUARE_SUB);
	wire take_st = take && (instr_op == sqa_pkg::OP_STORE_ST ||
		instr_op == sqa_pkg::OP_STORE_ST_N ||
		instr_op == sqa_pkg::OP_STORE_ST1);
	wire take_op7 = take && instr_op == sqa_pkg::OP_SET_TXM_TC;
	wire xmit_req = take_op7 && instr_sub == sqa_pkg::SUB_TRANSMIT;
	wire word1_wr = reg_wr && reg_addr == sqa_pkg::OFS_ST1;

	// ==========================================================
	// square walk: one operand read, then two stalled cycles
	sequence s_sq_read;
		mem_rd && !mem_wr ##1 !mem_rd;
	endsequence
	sequence s_sq_stall;
		!instr_ready [*2] ##1 instr_ready;
	endsequence

	a_sq_read: assert property (take_sq |=> s_sq_read)
		else $error("square op did not read its operand once");
	a_sq_stall: assert property (take_sq |=> s_sq_stall)
		else $error("square op stall length wrong");
	a_word0_store: assert property (take
		&& instr_op == sqa_pkg::OP_STORE_ST |=> mem_wr && mem_wdata[12:0] == 13'h0)
		else $error("status word zero store wrong");
	a_word1_store: assert property (take
		&& instr_op == sqa_pkg::OP_STORE_ST1 |=> mem_wr
		&& mem_wdata[11:10] == {test_control_flag, sign_extend_enable}
		&& mem_wdata[2] == serial_transmit_mode_bit)
		else $error("status word one store wrong");
	a_signext_set: assert property (take
		&& instr_op == sqa_pkg::OP_SET_SXM |=> sign_extend_enable)
		else $error("sign extension not set");
	a_flag_only: assert property (take_op7 && !instr_sub |=>
		test_control_flag && $stable(sign_extend_enable)
		&& $stable(serial_transmit_mode_bit) && !mem_wr && !mem_rd)
		else $error("test flag set changed other state");
	a_xmit_cause: assert property ($rose(serial_transmit_mode_bit)
		|-> $past(xmit_req) || $past(word1_wr))
		else $error("transmit mode rose with no cause");
	a_wr_cause: assert property (mem_wr |-> $past(take_st))
		else $error("write strobe with no store op");
endmodule

bind sqa_exec sqa_exec_asserts chk (.clk(clk), .reset_n(reset_n),
	.instr_valid(instr_valid), .instr_op(instr_op), .instr_sub(instr_sub),
	.instr_ready(instr_ready), .mem_rd(mem_rd), .mem_wr(mem_wr),
	.mem_wdata(mem_wdata), .reg_addr(reg_addr), .reg_wr(reg_wr),
	.sign_extend_enable(sign_extend_enable),
	.test_control_flag(test_control_flag),
	.serial_transmit_mode_bit(serial_transmit_mode_bit));
`default_nettype wire

// >>> verification/sqa_exec_bench.sv
// self-checking bench for the square-accumulate and status-op block.
// assumes sqa_pkg is compiled first and the checker is bound to uut.
`timescale 1ns/1ps
`default_nettype none
module sqa_exec_bench;
	// ==========================================================
	// signals and model state
	logic        clk, reset_n, instr_ready, mem_rd, mem_wr, sx_o, tc_o, tx_o;
	logic        instr_valid = 0, instr_sub = 0, instr_indirect = 0;
	logic        instr_next_valid = 0, instr_status_sel = 0;
	logic        reg_wr = 0, reg_rd = 0, rd_d = 0;
	logic [2:0]  instr_op = 0, instr_next_arp = 0;
	logic [1:0]  instr_modifier = 0;
	logic [3:0]  reg_addr = 0;
	logic [15:0] instr_direct_addr = 0, reg_wdata = 0, mem_rdata = 0;
	logic [15:0] mem_addr, mem_wdata, reg_rdata, mult, aux[8];
	logic [31:0] acc, prod;
	logic [2:0]  ptr;
	logic [1:0]  shm;
	logic        sx, tcf, tx, gen;
	logic [32:0] mq[$];
	logic [15:0] rq[$];
	int          n_mismatch = 0, n_tests = 0;

	sqa_exec uut (.clk(clk), .reset_n(reset_n), .instr_valid(instr_valid),
		.instr_op(instr_op), .instr_sub(instr_sub),
		.instr_indirect(instr_indirect), .instr_direct_addr(instr_direct_addr),
		.instr_modifier(instr_modifier), .instr_next_valid(instr_next_valid),
		.instr_next_arp(instr_next_arp), .instr_status_sel(instr_status_sel),
		.instr_ready(instr_ready), .mem_rd(mem_rd), .mem_wr(mem_wr),
		.mem_addr(mem_addr), .mem_wdata(mem_wdata), .mem_rdata(mem_rdata),
		.reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr),
		.reg_rd(reg_rd), .reg_rdata(reg_rdata), .sign_extend_enable(sx_o),
		.test_control_flag(tc_o), .serial_transmit_mode_bit(tx_o));

	initial begin
		clk = 0;
		forever #50 clk = ~clk;
	end

	// ==========================================================
	// checking and bus tasks
	task automatic chk(input logic [15:0] got, exp, input string m);
		n_tests++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h want %h", $time, m, got, exp);
		end
	endtask
	function automatic logic [15:0] stat1();
		return {4'h0, tcf, sx, 7'h0, tx, shm};
	endfunction
	task automatic wr(input logic [3:0] a, input logic [15:0] d);
		@(posedge clk);
		reg_wr <= 1'h1;
		reg_addr <= a;
		reg_wdata <= d;
		@(posedge clk);
		reg_wr <= 1'h0;
		if (a == 0) ptr = d[15:13];
		if (a == 1) {tcf, sx, tx, shm} = {d[11:10], d[2:0]};
		if (a == 2) acc[15:0] = d;
		if (a == 3) acc[31:16] = d;
		if (a == 7) gen = d[0];
		if (a >= 8) aux[a[2:0]] = d;
	endtask
	task automatic rd(input logic [3:0] a, input logic [15:0] exp);
		rq.push_back(exp);
		@(posedge clk);
		reg_rd <= 1'h1;
		reg_addr <= a;
		@(posedge clk);
		reg_rd <= 1'h0;
	endtask
	task automatic ins(input logic [2:0] op, input logic sub, ind,
		input logic [1:0] md, input logic nv, input logic [2:0] na,
		input logic sel);
		logic [15:0] a, d;
		logic [31:0] sh;
		a = ind ? aux[ptr] : 16'($urandom);
		d = 16'($urandom);
		@(posedge clk);
		{instr_valid, instr_op, instr_sub, instr_indirect} <= {1'h1, op, sub, ind};
		{instr_modifier, instr_next_valid, instr_next_arp} <= {md, nv, na};
		instr_status_sel <= sel;
		instr_direct_addr <= a;
		@(negedge clk);
		while (instr_ready !== 1'h1) @(negedge clk);
		@(posedge clk);
		instr_valid <= 1'h0;
		sh = shm == 0 ? prod : shm == 1 ? prod << 1 : shm == 2 ? prod << 4
			: $unsigned($signed(prod) >>> 6);
		case (op)
			1, 2: begin
				acc = op == 1 ? acc + sh : acc - sh;
				mult = d;
				prod = $signed(d) * $signed(d);
				mq.push_back({1'h0, a, d});
			end
			3: mq.push_back({1'h1, a, ptr, 13'h0});
			4: mq.push_back({1'h1, a, sel ? stat1() : {ptr, 13'h0}});
			5: mq.push_back({1'h1, a, stat1()});
			6: sx = 1;
			7: if (!sub) tcf = 1; else if (gen) tx = 1;
			default: ;
		endcase
		if (ind && md == sqa_pkg::MOD_INC) aux[ptr] = aux[ptr] + 16'h1;
		if (ind && md == sqa_pkg::MOD_DEC) aux[ptr] = aux[ptr] - 16'h1;
		if (ind && nv) ptr = na;
		if (op == 1 || op == 2) repeat (2) @(posedge clk);
	endtask

	// ==========================================================
	// monitor: memory port and register read data against notes
	always @(posedge clk) begin
		logic [32:0] e;
		if (mem_rd === 1'h1 || mem_wr === 1'h1) begin
			e = mq.pop_front();
			chk(16'(mem_wr), 16'(e[32]), "strobe kind");
			chk(mem_addr, e[31:16], "memory address");
			if (e[32]) chk(mem_wdata, e[15:0], "stored word");
			mem_rdata <= e[32] ? 16'($urandom) : e[15:0];
		end else mem_rdata <= 16'($urandom);
		if (rd_d) chk(reg_rdata, rq.pop_front(), "register read");
		rd_d <= reg_rd;
	end

	task automatic wrap_up();
		$display("checks %0d mismatches %0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	initial begin
		#(100 * 4000);
		n_mismatch++;
		$display("[ERR] %0t watchdog expired", $time);
		wrap_up();
	end

	// ==========================================================
	// tests
	initial begin
		int k;
		void'($urandom(63));
		{acc, prod, mult, ptr, shm, tcf, tx, gen, sx} = {88'h0, 1'h1};
		for (k = 0; k < 8; k++) aux[k] = 16'h0;
		reset_n = 1'h0;
		repeat (3) @(posedge clk);
		reset_n <= 1'h1;
		repeat (4) @(posedge clk);
		for (k = 0; k < 16; k++) rd(4'(k), k == 1 ? 16'h0400 : 16'h0);
		wr(sqa_pkg::OFS_TREG, 16'h1234);
		rd(sqa_pkg::OFS_TREG, 16'h0);
		$display("reset test done");
		for (k = 0; k < 8; k++) begin
			wr(sqa_pkg::OFS_ST1, {5'h0, 1'h1, 8'h0, 2'(k)});
			wr(sqa_pkg::OFS_ACC_LO, 16'($urandom));
			wr(sqa_pkg::OFS_ACC_HI, 16'($urandom));
			ins(3'(k < 4 ? 1 : 2), 0, 0, 0, 0, 0, 0);
			rd(sqa_pkg::OFS_ACC_LO, acc[15:0]);
			rd(sqa_pkg::OFS_ACC_HI, acc[31:16]);
			rd(sqa_pkg::OFS_P_LO, prod[15:0]);
			rd(sqa_pkg::OFS_P_HI, prod[31:16]);
			rd(sqa_pkg::OFS_TREG, mult);
		end
		$display("square test done");
		wr(sqa_pkg::OFS_ST0, 16'h6000);
		wr(4'hb, 16'($urandom));
		ins(sqa_pkg::OP_SQUARE_SUB, 0, 1, 1, 1, 3'h5, 0);
		for (k = 0; k < 3; k++)
			ins(sqa_pkg::OP_STORE_ST, 0, 1, 2'(k), 1, 3'($urandom), 0);
		for (k = 0; k < 8; k++) rd(4'(k + 8), aux[k]);
		$display("indirect test done");
		wr(sqa_pkg::OFS_ST1, 16'h0);
		ins(sqa_pkg::OP_SET_SXM, 0, 0, 0, 0, 0, 0);
		ins(sqa_pkg::OP_SET_TXM_TC, 0, 0, 0, 0, 0, 0);
		ins(sqa_pkg::OP_SET_TXM_TC, 1, 0, 0, 0, 0, 0);
		rd(sqa_pkg::OFS_ST1, stat1());
		wr(sqa_pkg::OFS_CTRL, 16'h1);
		ins(sqa_pkg::OP_SET_TXM_TC, 1, 0, 0, 0, 0, 0);
		@(negedge clk);
		chk(16'({sx_o, tc_o, tx_o}), 16'({sx, tcf, tx}), "status pins");
		ins(sqa_pkg::OP_STORE_ST, 0, 0, 0, 0, 0, 0);
		ins(sqa_pkg::OP_STORE_ST1, 0, 1, 2, 0, 0, 0);
		for (k = 0; k < 4; k++)
			ins(sqa_pkg::OP_STORE_ST_N, 0, k[1], 1, 0, 0, k[0]);
		repeat (4) @(posedge clk);
		chk(16'(mq.size() + rq.size()), 16'h0, "pending results");
		$display("status test done");
		wrap_up();
	end
endmodule
`default_nettype wire
